/* File: hw/acfs_aux_regs.sv */
`timescale 1ns/10ps
`default_nettype none
module acfs_aux_regs
	import acfs_pkg::*;
(
	input wire logic clk_in,
	input wire logic rst_in,
	input wire acfs_req_t req_in,
	output acfs_rsp_t rsp_out,
	output logic [31:0] aux_control_out,
	output logic [31:0] aux_fault_status_out
);

	// ----------------------------------------
	// Decode
	// ----------------------------------------
	function automatic acfs_hit_t acfs_decode(input logic [31:0] addr);
		acfs_hit_t res;
		case (addr)
			ACFS_AUX_CONTROL_ADDR: res = ACFS_HIT_CTRL;
			ACFS_AUX_FAULT_STATUS_ADDR: res = ACFS_HIT_FS;
			ACFS_AUX_CONTROL_NS_ALIAS_ADDR: res = ACFS_HIT_CTRL_ALIAS;
			ACFS_AUX_FAULT_STATUS_NS_ALIAS_ADDR: res = ACFS_HIT_FS_ALIAS;
			default: res = ACFS_HIT_NONE;
		endcase
		return res;
	endfunction

	acfs_bank_state_t state_r;
	acfs_bank_state_t state_nxt;
	acfs_hit_t hit;
	logic [ACFS_NUM_REGS-1:0] sel;
	logic [ACFS_NUM_REGS-1:0] wr_en;
	logic [31:0] word [ACFS_NUM_REGS];
	logic alias_hit;
	logic alias_blocked;
	logic refused;

	always_comb
	begin
		hit = acfs_decode(req_in.addr);
		alias_hit = (hit == ACFS_HIT_CTRL_ALIAS) || (hit == ACFS_HIT_FS_ALIAS);
		sel[ACFS_IDX_CONTROL] = (hit == ACFS_HIT_CTRL)
			|| (hit == ACFS_HIT_CTRL_ALIAS);
		sel[ACFS_IDX_FAULT_STATUS] = (hit == ACFS_HIT_FS)
			|| (hit == ACFS_HIT_FS_ALIAS);
		alias_blocked = alias_hit && (!req_in.secure || req_in.debugger);
		refused = (hit == ACFS_HIT_NONE) || !req_in.privileged;
	end

	// ----------------------------------------
	// Storage
	// ----------------------------------------
	// both always present
	genvar gi;
	generate
		for (gi = 0; gi < ACFS_NUM_REGS; gi++)
		begin : g_store
			assign wr_en[gi] = req_in.valid && req_in.write && sel[gi]
				&& !refused && !alias_blocked;
			acfs_word_store u_store (
				.clk_in(clk_in),
				.rst_in(rst_in),
				.wr_en_in(wr_en[gi]),
				.wdata_in(req_in.wdata),
				.word_out(word[gi])
			);
		end
	endgenerate

	// ----------------------------------------
	// Answer
	// ----------------------------------------
	always_comb
	begin
		state_nxt = state_r;
		state_nxt.rsp.valid = req_in.valid;
		state_nxt.rsp.err = 1'b0;
		state_nxt.rsp.rdata = ACFS_READ_ZERO;
		if (req_in.valid)
		begin
			// error in the normal answer cycle
			if (refused)
			begin
				state_nxt.rsp.err = 1'b1;
			end
			else if (!req_in.write && !alias_blocked)
			begin
				if (sel[ACFS_IDX_CONTROL])
				begin
					state_nxt.rsp.rdata = word[ACFS_IDX_CONTROL];
				end
				else
				begin
					state_nxt.rsp.rdata = word[ACFS_IDX_FAULT_STATUS];
				end
			end
		end
	end

	always_ff @(posedge clk_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			state_r <= '{rsp: '{valid: 1'b0, err: 1'b0, rdata: ACFS_READ_ZERO}};
		end
		else
		begin
			state_r <= state_nxt;
		end
	end

	assign rsp_out = state_r.rsp;
	assign aux_control_out = word[ACFS_IDX_CONTROL];
	assign aux_fault_status_out = word[ACFS_IDX_FAULT_STATUS];

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	chk_unpriv_error: assert property (
		@(posedge clk_in) disable iff (rst_in)
		req_in.valid && !req_in.privileged && hit != ACFS_HIT_NONE
		|=> rsp_out.valid && rsp_out.err && $stable(aux_control_out)
		&& $stable(aux_fault_status_out))
		else $error("unprivileged access not refused");

	chk_ctrl_write: assert property (
		@(posedge clk_in) disable iff (rst_in)
		req_in.valid && req_in.write && req_in.privileged
		&& hit == ACFS_HIT_CTRL
		|=> aux_control_out == $past(req_in.wdata) && !rsp_out.err)
		else $error("control write not stored");

	chk_ctrl_read: assert property (
		@(posedge clk_in) disable iff (rst_in)
		req_in.valid && !req_in.write && req_in.privileged
		&& hit == ACFS_HIT_CTRL
		|=> !rsp_out.err && rsp_out.rdata == $past(aux_control_out))
		else $error("control read wrong");

	chk_fs_write: assert property (
		@(posedge clk_in) disable iff (rst_in)
		req_in.valid && req_in.write && req_in.privileged
		&& hit == ACFS_HIT_FS
		|=> aux_fault_status_out == $past(req_in.wdata) && rsp_out.valid
		&& !rsp_out.err && rsp_out.rdata == ACFS_READ_ZERO)
		else $error("fault status write not stored");

	chk_fs_read: assert property (
		@(posedge clk_in) disable iff (rst_in)
		req_in.valid && !req_in.write && req_in.privileged
		&& hit == ACFS_HIT_FS
		|=> !rsp_out.err && rsp_out.rdata == $past(aux_fault_status_out))
		else $error("fault status read wrong");

	chk_alias_secure: assert property (
		@(posedge clk_in) disable iff (rst_in)
		req_in.valid && req_in.write && req_in.privileged && req_in.secure
		&& !req_in.debugger && hit == ACFS_HIT_CTRL_ALIAS
		|=> aux_control_out == $past(req_in.wdata))
		else $error("secure alias write lost");

	chk_fs_alias_write: assert property (
		@(posedge clk_in) disable iff (rst_in)
		req_in.valid && req_in.write && req_in.privileged && req_in.secure
		&& !req_in.debugger && hit == ACFS_HIT_FS_ALIAS
		|=> aux_fault_status_out == $past(req_in.wdata))
		else $error("secure status alias write lost");

	chk_ctrl_alias_raz: assert property (
		@(posedge clk_in) disable iff (rst_in)
		req_in.valid && req_in.privileged && hit == ACFS_HIT_CTRL_ALIAS
		&& (!req_in.secure || req_in.debugger)
		|=> rsp_out.valid && !rsp_out.err && rsp_out.rdata == ACFS_READ_ZERO
		&& $stable(aux_control_out))
		else $error("control alias not hidden");

	chk_fs_alias_raz: assert property (
		@(posedge clk_in) disable iff (rst_in)
		req_in.valid && req_in.privileged && hit == ACFS_HIT_FS_ALIAS
		&& (!req_in.secure || req_in.debugger)
		|=> rsp_out.valid && !rsp_out.err && rsp_out.rdata == ACFS_READ_ZERO
		&& $stable(aux_fault_status_out))
		else $error("fault status alias not hidden");

	chk_alias_shared: assert property (
		@(posedge clk_in) disable iff (rst_in)
		req_in.valid && !req_in.write && req_in.privileged && req_in.secure
		&& !req_in.debugger && hit == ACFS_HIT_FS_ALIAS
		|=> rsp_out.rdata == $past(aux_fault_status_out))
		else $error("alias read not from shared storage");

	chk_ctrl_alias_read: assert property (
		@(posedge clk_in) disable iff (rst_in)
		req_in.valid && !req_in.write && req_in.privileged && req_in.secure
		&& !req_in.debugger && hit == ACFS_HIT_CTRL_ALIAS
		|=> rsp_out.rdata == $past(aux_control_out))
		else $error("control alias read not shared");

	chk_regs_separate: assert property (
		@(posedge clk_in) disable iff (rst_in)
		req_in.valid && (hit == ACFS_HIT_FS || hit == ACFS_HIT_FS_ALIAS)
		|=> $stable(aux_control_out))
		else $error("status access changed control");

	chk_hold_idle: assert property (
		@(posedge clk_in) disable iff (rst_in)
		!(req_in.valid && req_in.write)
		|=> $stable(aux_control_out) && $stable(aux_fault_status_out))
		else $error("register changed without a write");

	chk_answer_time: assert property (
		@(posedge clk_in) disable iff (rst_in)
		req_in.valid |=> rsp_out.valid)
		else $error("answer not in the next cycle");

	chk_unmapped_error: assert property (
		@(posedge clk_in) disable iff (rst_in)
		req_in.valid && hit == ACFS_HIT_NONE
		|=> rsp_out.valid && rsp_out.err && rsp_out.rdata == ACFS_READ_ZERO
		&& $stable(aux_control_out) && $stable(aux_fault_status_out))
		else $error("unmapped access not refused");

	chk_write_no_data: assert property (
		@(posedge clk_in) disable iff (rst_in)
		req_in.valid && req_in.write
		|=> rsp_out.valid && rsp_out.rdata == ACFS_READ_ZERO)
		else $error("write answer carries data");

endmodule // acfs_aux_regs
`default_nettype wire

/* File: hw/acfs_pkg.sv */
package acfs_pkg;

	// ----------------------------------------
	// Address map
	// ----------------------------------------
	localparam logic [31:0] ACFS_AUX_CONTROL_ADDR = 32'he000e008;
	localparam logic [31:0] ACFS_AUX_FAULT_STATUS_ADDR = 32'he000ed3c;
	localparam logic [31:0] ACFS_AUX_CONTROL_NS_ALIAS_ADDR = 32'he002e008;
	localparam logic [31:0] ACFS_AUX_FAULT_STATUS_NS_ALIAS_ADDR = 32'he002ed3c;

	// ----------------------------------------
	// Storage layout and reset values
	// ----------------------------------------
	localparam int ACFS_NUM_REGS = 2;
	localparam int ACFS_IDX_CONTROL = 0;
	localparam int ACFS_IDX_FAULT_STATUS = 1;
	localparam logic [31:0] ACFS_REG_RESET = 32'h0000_0000;
	localparam logic [31:0] ACFS_READ_ZERO = 32'h0000_0000;

	// ----------------------------------------
	// Carriers
	// ----------------------------------------
	typedef struct packed {
		logic valid;
		logic write;
		logic privileged;
		logic secure;
		logic debugger;
		logic [31:0] addr;
		logic [31:0] wdata;
	} acfs_req_t;

	typedef struct packed {
		logic valid;
		logic err;
		logic [31:0] rdata;
	} acfs_rsp_t;

	// Address decode result, one-hot
	typedef enum logic [4:0] {
		ACFS_HIT_NONE = 5'h01,
		ACFS_HIT_CTRL = 5'h02,
		ACFS_HIT_FS = 5'h04,
		ACFS_HIT_CTRL_ALIAS = 5'h08,
		ACFS_HIT_FS_ALIAS = 5'h10
	} acfs_hit_t;

	typedef struct packed {
		acfs_rsp_t rsp;
	} acfs_bank_state_t;

	typedef struct packed {
		logic [31:0] word;
	} acfs_store_state_t;

endpackage

/* File: hw/acfs_word_store.sv */
`timescale 1ns/10ps
`default_nettype none
module acfs_word_store
	import acfs_pkg::*;
(
	input wire logic clk_in,
	input wire logic rst_in,
	input wire logic wr_en_in,
	input wire logic [31:0] wdata_in,
	output logic [31:0] word_out
);

	acfs_store_state_t state_r;
	acfs_store_state_t state_nxt;

	always_comb
	begin
		state_nxt = state_r;
		if (wr_en_in)
		begin
			state_nxt.word = wdata_in;
		end
	end

	always_ff @(posedge clk_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			state_r <= '{word: ACFS_REG_RESET};
		end
		else
		begin
			state_r <= state_nxt;
		end
	end

	assign word_out = state_r.word;

endmodule // acfs_word_store
`default_nettype wire

/* File: test/acfs_req_model.sv */
`timescale 1ns/10ps
`default_nettype none
module acfs_req_model
	import acfs_pkg::*;
(
	input wire logic clk_in,
	output acfs_req_t req_out
);
	initial req_out = '0;

	// word only
	// One full word per take; released fields show their inverse
	task automatic xfer(input acfs_req_t r);
		@(posedge clk_in);
		#1 req_out = r;
		@(posedge clk_in);
		#1 req_out = {1'b0, ~r[$bits(r)-2:0]};
	endtask
endmodule // acfs_req_model
`default_nettype wire

/* File: test/tb_aux_ctrl_fault_status_regs.sv */
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, e) \
	begin \
		samples_checked++; \
		if ((g) !== (e)) \
		begin \
			n_mismatch++; \
			$display("wrong value at %0t: output differs", $time); \
		end \
	end
module tb_aux_ctrl_fault_status_regs
	import acfs_pkg::*;
;
	logic clk_in = 1'b0;
	logic rst_in = 1'b1;
	acfs_req_t req;
	acfs_req_t r;
	acfs_rsp_t rsp;
	acfs_rsp_t x;
	logic [31:0] ctl_out, fs_out, ctl, fs, st, v;
	logic [31:0] tbl [4] = '{ACFS_AUX_CONTROL_ADDR, ACFS_AUX_FAULT_STATUS_ADDR,
		ACFS_AUX_CONTROL_NS_ALIAS_ADDR, ACFS_AUX_FAULT_STATUS_NS_ALIAS_ADDR};
	int n_mismatch = 0;
	int samples_checked = 0;

	always #2.5 clk_in = ~clk_in;

	acfs_req_model REQ (.clk_in(clk_in), .req_out(req));
	acfs_aux_regs DUT (.clk_in(clk_in), .rst_in(rst_in), .req_in(req),
		.rsp_out(rsp), .aux_control_out(ctl_out),
		.aux_fault_status_out(fs_out));

	function automatic logic [31:0] rnd();
		st ^= st << 13;
		st ^= st >> 17;
		st ^= st << 5;
		return st;
	endfunction

	// Reference answer; alias addresses carry bit 17
	function automatic acfs_rsp_t expect_rsp(acfs_req_t q);
		acfs_rsp_t e;
		logic c, f;
		c = q.addr inside {ACFS_AUX_CONTROL_ADDR, ACFS_AUX_CONTROL_NS_ALIAS_ADDR};
		f = q.addr inside {ACFS_AUX_FAULT_STATUS_ADDR,
			ACFS_AUX_FAULT_STATUS_NS_ALIAS_ADDR};
		e = '{1'b1, !(q.privileged && (c || f)), 32'h0};
		if (e.err || (q.addr[17] && (!q.secure || q.debugger)))
			return e;
		if (q.write && c)
			ctl = q.wdata;
		if (q.write && f)
			fs = q.wdata;
		if (!q.write)
			e.rdata = c ? ctl : fs;
		return e;
	endfunction

	task automatic run(input acfs_req_t q);
		x = expect_rsp(q);
		REQ.xfer(q);
		`CHK(rsp, x)
		`CHK(ctl_out, ctl)
		`CHK(fs_out, fs)
	endtask

	task automatic end_of_test();
		$display("checked %0d mismatches %0d", samples_checked, n_mismatch);
		if (n_mismatch == 0 && samples_checked > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	initial
	begin
		#100us;
		n_mismatch++;
		end_of_test();
	end

	initial
	begin
		st = 32'h39869ca2;
		ctl = '0;
		fs = '0;
		repeat (2) @(posedge clk_in);
		#1 rst_in = 1'b0;
		`CHK({ctl_out, fs_out}, 64'h0)
		run('{1'b1, 1'b1, 1'b1, 1'b1, 1'b0, tbl[2], 32'ha5a5_0ff0});
		run('{1'b1, 1'b0, 1'b1, 1'b0, 1'b0, tbl[0], 32'h0});
		run('{1'b1, 1'b1, 1'b1, 1'b0, 1'b0, tbl[3], 32'hffff_ffff});
		run('{1'b1, 1'b1, 1'b0, 1'b1, 1'b0, tbl[1], 32'h1});
		run('{1'b1, 1'b0, 1'b1, 1'b1, 1'b1, tbl[2], 32'h0});
		run('{1'b1, 1'b1, 1'b1, 1'b1, 1'b0, tbl[1], 32'hffff_ffff});
		for (int i = 0; i < 600; i++)
		begin
			v = rnd();
			r = '{1'b1, v[0], v[3:1] != 0, v[4], v[6:5] == 0, tbl[v[9:8]], rnd()};
			if (v[12:10] == 0)
				r.addr = rnd();
			run(r);
			if (i == 300)
			begin
				rst_in = 1'b1;
				ctl = '0;
				fs = '0;
				@(posedge clk_in);
				#1 rst_in = 1'b0;
				`CHK({ctl_out, fs_out}, 64'h0)
			end
		end
		end_of_test();
	end
endmodule // tb_aux_ctrl_fault_status_regs
`default_nettype wire
